// *** common/rsq_pkg.sv ***
package rsq_pkg;

	// Core clock
	localparam int CLK_MHZ = 125;

	// Sequence trigger filter time
	localparam int DEGLITCH_US = 1000;

	// Power-on and power-off rail delays, in microseconds
	localparam int B1_DLY_US = 1500;
	localparam int B2_DLY_US = 2000;
	localparam int L1_DLY_US = 3000;
	localparam int L2_DLY_US = 6000;

	// Soft-start step dwell
	localparam int SS_STEP_US = 100;

	// Light-load persistence before pulse-frequency entry, switching ticks
	localparam int PFM_ENTRY_TICKS = 32;

	// Pulse-frequency band above nominal, per mille
	localparam int PFM_BAND_LO_PM = 8;
	localparam int PFM_BAND_HI_PM = 16;

	// Current limit codes in mA
	localparam int ILIM_W = 11;
	localparam logic [ILIM_W-1:0] B1_ILIM_S0 = 11'h0b4;
	localparam logic [ILIM_W-1:0] B1_ILIM_S1 = 11'h12c;
	localparam logic [ILIM_W-1:0] B1_ILIM_S2 = 11'h2d0;
	localparam logic [ILIM_W-1:0] B1_ILIM_RUN = 11'h5dc;
	localparam logic [ILIM_W-1:0] B2_ILIM_S0 = 11'h0a1;
	localparam logic [ILIM_W-1:0] B2_ILIM_S1 = 11'h12c;
	localparam logic [ILIM_W-1:0] B2_ILIM_S2 = 11'h218;
	localparam logic [ILIM_W-1:0] B2_ILIM_RUN = 11'h3e8;

	// Reset values of the software enables and force bits
	localparam logic [3:0] REG_EN_RST = 4'hf;
	localparam logic [1:0] FORCE_PWM_RST = 2'h0;

	// Rail positions in the rail vectors
	localparam int RAIL_B1 = 0;
	localparam int RAIL_B2 = 1;
	localparam int RAIL_L1 = 2;
	localparam int RAIL_L2 = 3;

	// Exact because the clock is a whole number of MHz
	function automatic int us_to_cyc(input int us);
		return us * CLK_MHZ;
	endfunction

	localparam int DEGLITCH_CYC_DEF = us_to_cyc(DEGLITCH_US);
	localparam int B1_DLY_CYC = us_to_cyc(B1_DLY_US);
	localparam int B2_DLY_CYC = us_to_cyc(B2_DLY_US);
	localparam int L1_DLY_CYC = us_to_cyc(L1_DLY_US);
	localparam int L2_DLY_CYC = us_to_cyc(L2_DLY_US);
	localparam int SS_STEP_CYC_DEF = us_to_cyc(SS_STEP_US);

	typedef enum logic [1:0] {
		SEQ_STANDBY,
		SEQ_UP,
		SEQ_ACTIVE,
		SEQ_DOWN
	} rsq_seq_t;

	typedef enum logic [2:0] {
		BK_OFF,
		BK_SOFT,
		BK_PWM,
		BK_PFM_SLEEP,
		BK_PFM_HS,
		BK_PFM_LS,
		BK_PFM_PARK
	} rsq_buck_t;

endpackage

// *** rtl/rsq_deglitch.sv ***
`timescale 1ns/1ps
module rsq_deglitch
	import rsq_pkg::*;
#(
	parameter int CYC = DEGLITCH_CYC_DEF
)(
	input wire logic sys_clk, // Core clock
	input wire logic rst_b, // Async reset, active low
	input wire logic raw, // Unfiltered level
	output logic level, // Filtered level
	output logic rise, // One-cycle pulse on accepted rise
	output logic fall // One-cycle pulse on accepted fall
);
	localparam int CW = $clog2(CYC + 1);

	generate
		if (CYC < 1) begin : g_chk
			$error("rsq_deglitch: CYC must be at least 1");
		end
	endgenerate

	logic [CW-1:0] cnt;
	wire differs = raw != level;
	wire accept = differs && (cnt == CW'(CYC - 1));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
			level <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			cnt <= (differs && !accept) ? cnt + 1'b1 : '0;
			if (accept) begin
				level <= raw;
			end
			rise <= accept && raw;
			fall <= accept && !raw;
		end
	end
endmodule

// *** rtl/rsq_softstart.sv ***
`timescale 1ns/1ps
module rsq_softstart
	import rsq_pkg::*;
#(
	parameter logic [ILIM_W-1:0] S0 = B1_ILIM_S0,
	parameter logic [ILIM_W-1:0] S1 = B1_ILIM_S1,
	parameter logic [ILIM_W-1:0] S2 = B1_ILIM_S2,
	parameter logic [ILIM_W-1:0] RUN = B1_ILIM_RUN,
	parameter int STEP_CYC = SS_STEP_CYC_DEF
)(
	input wire logic sys_clk, // Core clock
	input wire logic rst_b, // Async reset, active low
	input wire logic run, // Converter enabled
	output logic [ILIM_W-1:0] ilim, // Switch current limit, mA
	output logic done // Soft start finished
);
	localparam int CW = $clog2(STEP_CYC + 1);

	generate
		if (STEP_CYC < 1) begin : g_chk
			$error("rsq_softstart: STEP_CYC must be at least 1");
		end
	endgenerate

	logic [CW-1:0] cnt;
	logic [1:0] idx;
	wire step_end = cnt == CW'(STEP_CYC - 1);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
			idx <= 2'h0;
			done <= 1'b0;
			ilim <= S0;
		end else if (!run) begin
			// A fresh ramp on every low-to-high enable
			cnt <= '0;
			idx <= 2'h0;
			done <= 1'b0;
			ilim <= S0;
		end else if (!done) begin
			cnt <= step_end ? '0 : cnt + 1'b1;
			if (step_end) begin
				idx <= idx + 1'b1;
				done <= idx == 2'h2;
				ilim <= (idx == 2'h0) ? S1 : (idx == 2'h1) ? S2 : RUN;
			end
		end
	end
endmodule

// *** rtl/rsq_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - PFM low threshold turns high side on until high threshold or peak limit
// - PFM band sits 0.8 to 1.6 percent above nominal PWM output
// - After high side, low side on until zero current detected
// - Still below high threshold after low side: pulse again
// - At high threshold, low side to zero current, then sleep
// - Below the second low threshold in PFM: switch to PWM
// - Bucks enabled on power-on to Active; default voltages loaded at end
// - Software enables or disables each converter individually
// - Automatic mode by default; force bit holds PWM
// - Soft start only on enable rise after input supply is valid
// - Soft start limits 180/300/720 mA and 161/300/536 mA
// - Near dropout the high side stays on, no switching, in soft start and PWM only
// - Each of the four rails has its own pin enable
// - Trigger rise leaves Standby and starts power-on timing
// - Trigger fall starts the shutdown timing
// - Trigger is deglitched for 1 ms before use
// - While trigger is high, pin enable toggling is ignored
// - Rail on = register enable AND (pin enable OR trigger)
// - Register enables are all set after reset
// - Undriven enables read low, so every rail stays off
// - Power-on delays 1.5, 2, 3, 6 ms per rail
// - Power-off delays 1.5, 2, 3, 6 ms per rail
// - PFM entry after 32 switching cycles of light load
module rsq_top
	import rsq_pkg::*;
#(
	parameter int DEGLITCH_CYC = DEGLITCH_CYC_DEF,
	parameter int B1_ON_CYC = B1_DLY_CYC,
	parameter int B2_ON_CYC = B2_DLY_CYC,
	parameter int L1_ON_CYC = L1_DLY_CYC,
	parameter int L2_ON_CYC = L2_DLY_CYC,
	parameter int B1_OFF_CYC = B1_DLY_CYC,
	parameter int B2_OFF_CYC = B2_DLY_CYC,
	parameter int L1_OFF_CYC = L1_DLY_CYC,
	parameter int L2_OFF_CYC = L2_DLY_CYC,
	parameter int SS_STEP_CYC = SS_STEP_CYC_DEF,
	parameter int PFM_TICKS = PFM_ENTRY_TICKS
)(
	input wire logic sys_clk, // Core clock, 125 MHz
	input wire logic rst_b, // Power-on reset, active low
	input wire logic sequence_trigger_input, // Sequence trigger pin
	input wire logic buck_one_pin_enable, // Pin enable, buck one
	input wire logic buck_two_pin_enable, // Pin enable, buck two
	input wire logic linreg_one_pin_enable, // Pin enable, linreg one
	input wire logic linreg_two_pin_enable, // Pin enable, linreg two
	input wire logic vin_ok, // Input supply above lockout
	input wire logic reg_en_wr, // Write strobe for reg_en_wdata
	input wire logic [3:0] reg_en_wdata, // Software rail enables
	input wire logic force_pwm_wr, // Write strobe for force_pwm_wdata
	input wire logic [1:0] force_pwm_wdata, // Force PWM per buck
	input wire logic sw_tick, // Switching clock enable pulse
	input wire logic [1:0] fb_below_low, // Output under low PFM threshold
	input wire logic [1:0] fb_above_high, // Output over high PFM threshold
	input wire logic [1:0] fb_below_low2, // Output under low2 threshold
	input wire logic [1:0] pfm_peak_hit, // Peak reached PFM limit
	input wire logic [1:0] zero_current, // Inductor current at zero
	input wire logic [1:0] light_load, // Discontinuous or low peak
	input wire logic [1:0] pwm_hs_req, // PWM modulator high-side demand
	input wire logic [1:0] dropout, // Input close to output
	output logic [3:0] rail_on, // Rail enables, buck one in bit 0
	output logic [3:0] reg_en, // Software rail enables readback
	output logic [1:0] force_pwm, // Force PWM readback
	output logic trigger_level, // Filtered trigger level
	output logic seq_busy, // Power-on or power-off timing runs
	output logic load_vout_default, // Pulse: load default voltages
	output logic [1:0] buck_hs_on, // High-side switch drive
	output logic [1:0] buck_ls_on, // Low-side switch drive
	output logic [1:0] buck_pwm_mode, // Fixed-frequency mode
	output logic [1:0] buck_pfm_sleep, // PFM sleep, both switches off
	output logic [ILIM_W-1:0] buck_one_ilim, // Buck one limit, mA
	output logic [ILIM_W-1:0] buck_two_ilim // Buck two limit, mA
);
	localparam int SEQ_W = 20;
	localparam int LW = $clog2(PFM_TICKS + 1);

	function automatic int max4(input int a, input int b, input int c,
		input int d);
		int m;
		m = a;
		if (b > m) m = b;
		if (c > m) m = c;
		if (d > m) m = d;
		return m;
	endfunction

	localparam int ON_MAX = max4(B1_ON_CYC, B2_ON_CYC, L1_ON_CYC, L2_ON_CYC);
	localparam int OFF_MAX = max4(B1_OFF_CYC, B2_OFF_CYC, L1_OFF_CYC,
		L2_OFF_CYC);

	generate
		if (ON_MAX >= (1 << SEQ_W) || OFF_MAX >= (1 << SEQ_W)) begin : g_c1
			$error("rsq_top: sequence delay exceeds counter range");
		end
		if (PFM_TICKS < 1) begin : g_c2
			$error("rsq_top: PFM_TICKS must be at least 1");
		end
	endgenerate

	localparam logic [SEQ_W-1:0] ON_L[4] = '{SEQ_W'(B1_ON_CYC),
		SEQ_W'(B2_ON_CYC), SEQ_W'(L1_ON_CYC), SEQ_W'(L2_ON_CYC)};
	localparam logic [SEQ_W-1:0] OFF_L[4] = '{SEQ_W'(B1_OFF_CYC),
		SEQ_W'(B2_OFF_CYC), SEQ_W'(L1_OFF_CYC), SEQ_W'(L2_OFF_CYC)};

	// Trigger filter
	logic trig_rise;
	logic trig_fall;

	rsq_deglitch #(.CYC(DEGLITCH_CYC)) u_deglitch (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.raw(sequence_trigger_input),
		.level(trigger_level),
		.rise(trig_rise),
		.fall(trig_fall)
	);

	// Software enables and force bits
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_en <= REG_EN_RST;
			force_pwm <= FORCE_PWM_RST;
		end else begin
			if (reg_en_wr) reg_en <= reg_en_wdata;
			if (force_pwm_wr) force_pwm <= force_pwm_wdata;
		end
	end

	// Pin enables are frozen while the trigger is high
	wire [3:0] pins = {linreg_two_pin_enable, linreg_one_pin_enable,
		buck_two_pin_enable, buck_one_pin_enable};
	logic [3:0] pin_hold;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_hold <= 4'h0;
		end else if (!trigger_level) begin
			pin_hold <= pins;
		end
	end

	// Power-on / power-off timer
	rsq_seq_t seq_st;
	rsq_seq_t next_seq_st;
	logic [SEQ_W-1:0] seq_cnt;
	logic [3:0] seq_on;
	logic [3:0] on_hit;
	logic [3:0] off_hit;

	genvar r;
	for (r = 0; r < 4; r++) begin : g_hit
		assign on_hit[r] = seq_cnt >= ON_L[r];
		assign off_hit[r] = seq_cnt >= OFF_L[r];
	end

	wire up_done = seq_cnt >= SEQ_W'(ON_MAX);
	wire down_done = seq_cnt >= SEQ_W'(OFF_MAX);

	always_comb begin
		next_seq_st = seq_st;
		case (seq_st)
			SEQ_STANDBY: if (trig_rise) next_seq_st = SEQ_UP;
			SEQ_UP: begin
				if (trig_fall) next_seq_st = SEQ_DOWN;
				else if (up_done) next_seq_st = SEQ_ACTIVE;
			end
			SEQ_ACTIVE: if (trig_fall) next_seq_st = SEQ_DOWN;
			SEQ_DOWN: begin
				if (trig_rise) next_seq_st = SEQ_UP;
				else if (down_done) next_seq_st = SEQ_STANDBY;
			end
			default: next_seq_st = SEQ_STANDBY;
		endcase
	end

	wire seq_restart = next_seq_st != seq_st;
	wire counting = seq_st == SEQ_UP || seq_st == SEQ_DOWN;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			seq_st <= SEQ_STANDBY;
			seq_cnt <= '0;
			seq_on <= 4'h0;
			load_vout_default <= 1'b0;
			seq_busy <= 1'b0;
		end else begin
			seq_st <= next_seq_st;
			seq_cnt <= (seq_restart || !counting) ? '0 : seq_cnt + 1'b1;
			if (seq_st == SEQ_UP) seq_on <= seq_on | on_hit;
			if (seq_st == SEQ_DOWN) seq_on <= seq_on & ~off_hit;
			load_vout_default <= seq_st == SEQ_UP &&
				next_seq_st == SEQ_ACTIVE;
			seq_busy <= next_seq_st == SEQ_UP || next_seq_st == SEQ_DOWN;
		end
	end

	// Lockout gates every rail; enables only rise once the supply is valid
	wire [3:0] next_rail = reg_en & (pin_hold | seq_on) & {4{vin_ok}};

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) rail_on <= 4'h0;
		else rail_on <= next_rail;
	end

	// Per-converter mode control
	logic [ILIM_W-1:0] ss_ilim[2];
	logic [1:0] ss_done;
	rsq_buck_t bk_st[2];
	rsq_buck_t next_bk_st[2];
	logic [LW-1:0] lt_cnt[2];

	assign buck_one_ilim = ss_ilim[0];
	assign buck_two_ilim = ss_ilim[1];

	genvar g;
	for (g = 0; g < 2; g++) begin : g_buck
		wire en = rail_on[g];
		wire in_pfm = bk_st[g] == BK_PFM_SLEEP || bk_st[g] == BK_PFM_HS ||
			bk_st[g] == BK_PFM_LS || bk_st[g] == BK_PFM_PARK;
		wire light_full = lt_cnt[g] == LW'(PFM_TICKS - 1);
		wire pfm_go = sw_tick && light_load[g] && light_full &&
			!force_pwm[g];
		wire pwm_like = next_bk_st[g] == BK_PWM ||
			next_bk_st[g] == BK_SOFT;
		wire hs_pwm = dropout[g] || pwm_hs_req[g];

		rsq_softstart #(
			.S0(g == 0 ? B1_ILIM_S0 : B2_ILIM_S0),
			.S1(g == 0 ? B1_ILIM_S1 : B2_ILIM_S1),
			.S2(g == 0 ? B1_ILIM_S2 : B2_ILIM_S2),
			.RUN(g == 0 ? B1_ILIM_RUN : B2_ILIM_RUN),
			.STEP_CYC(SS_STEP_CYC)
		) u_ss (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.run(en),
			.ilim(ss_ilim[g]),
			.done(ss_done[g])
		);

		always_comb begin
			next_bk_st[g] = bk_st[g];
			case (bk_st[g])
				BK_OFF: if (en) next_bk_st[g] = BK_SOFT;
				BK_SOFT: if (ss_done[g]) next_bk_st[g] = BK_PWM;
				BK_PWM: if (pfm_go) next_bk_st[g] = BK_PFM_SLEEP;
				BK_PFM_SLEEP: begin
					if (fb_below_low[g]) next_bk_st[g] = BK_PFM_HS;
				end
				BK_PFM_HS: begin
					if (fb_above_high[g]) next_bk_st[g] = BK_PFM_PARK;
					else if (pfm_peak_hit[g]) next_bk_st[g] = BK_PFM_LS;
				end
				BK_PFM_LS: begin
					if (zero_current[g]) begin
						next_bk_st[g] = fb_above_high[g] ? BK_PFM_SLEEP :
							BK_PFM_HS;
					end
				end
				BK_PFM_PARK: begin
					if (zero_current[g]) next_bk_st[g] = BK_PFM_SLEEP;
				end
				default: next_bk_st[g] = BK_OFF;
			endcase
			// Load step or software override outranks the pulse sequence
			if (in_pfm && (fb_below_low2[g] || force_pwm[g])) begin
				next_bk_st[g] = BK_PWM;
			end
			if (!en) next_bk_st[g] = BK_OFF;
		end

		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				bk_st[g] <= BK_OFF;
				lt_cnt[g] <= '0;
				buck_hs_on[g] <= 1'b0;
				buck_ls_on[g] <= 1'b0;
				buck_pwm_mode[g] <= 1'b0;
				buck_pfm_sleep[g] <= 1'b0;
			end else begin
				bk_st[g] <= next_bk_st[g];
				if (bk_st[g] != BK_PWM || !light_load[g]) begin
					lt_cnt[g] <= '0;
				end else if (sw_tick && !light_full) begin
					lt_cnt[g] <= lt_cnt[g] + 1'b1;
				end
				buck_hs_on[g] <= (pwm_like && hs_pwm) ||
					next_bk_st[g] == BK_PFM_HS;
				buck_ls_on[g] <= (pwm_like && !hs_pwm) ||
					next_bk_st[g] == BK_PFM_LS ||
					next_bk_st[g] == BK_PFM_PARK;
				buck_pwm_mode[g] <= pwm_like;
				// Comparators sit in the PFM band above nominal
				buck_pfm_sleep[g] <= next_bk_st[g] == BK_PFM_SLEEP;
			end
		end
	end
endmodule

// *** testbench/rsq_top_props.sv ***
`timescale 1ns/1ps
module rsq_top_props
	import rsq_pkg::*;
#(
	parameter int DEGLITCH_CYC = DEGLITCH_CYC_DEF
)(
	input wire logic sys_clk, // Clock
	input wire logic rst_b, // Reset
	input wire logic sequence_trigger_input, // Raw trigger
	input wire logic vin_ok, // Supply ok
	input wire logic [1:0] dropout, // Dropout
	input wire logic [1:0] fb_below_low, // Low threshold
	input wire logic [1:0] fb_below_low2, // Low2 threshold
	input wire logic [3:0] rail_on, // Rails
	input wire logic [3:0] reg_en, // Soft enables
	input wire logic [1:0] force_pwm, // Force bits
	input wire logic trigger_level, // Filtered trigger
	input wire logic seq_busy, // Timing runs
	input wire logic load_vout_default, // Load pulse
	input wire logic [1:0] buck_hs_on, // High side
	input wire logic [1:0] buck_ls_on, // Low side
	input wire logic [1:0] buck_pwm_mode, // PWM mode
	input wire logic [1:0] buck_pfm_sleep, // Sleep
	input wire logic [ILIM_W-1:0] buck_one_ilim // Limit
);
	logic [31:0] hi_run;
	logic [31:0] lo_run;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Raw run lengths bound the moment the filter may flip
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_run <= 32'h0;
			lo_run <= 32'h0;
		end else begin
			hi_run <= sequence_trigger_input ? hi_run + 32'h1 : 32'h0;
			lo_run <= sequence_trigger_input ? 32'h0 : lo_run + 32'h1;
		end
	end
	chk_rise_filter: assert property (
		$rose(trigger_level) |-> hi_run >= DEGLITCH_CYC - 2 &&
		hi_run <= DEGLITCH_CYC + 2) else $error("trigger rose off time");
	chk_fall_filter: assert property (
		$fell(trigger_level) |-> lo_run >= DEGLITCH_CYC - 2 &&
		lo_run <= DEGLITCH_CYC + 2) else $error("trigger fell off time");
	chk_seq_start: assert property (
		$rose(trigger_level) |-> ##[1:3] seq_busy)
		else $error("no power-on timing");
	chk_seq_stop: assert property (
		$fell(trigger_level) |-> ##[1:3] seq_busy)
		else $error("no shutdown timing");
	chk_load_pulse: assert property (
		load_vout_default |-> trigger_level ##1 !load_vout_default)
		else $error("bad default load pulse");
	chk_rail_gate: assert property (
		(rail_on & ~($past(reg_en) & {4{$past(vin_ok)}})) == 4'h0)
		else $error("rail on without enable");
	chk_ilim_steps: assert property (
		$changed(buck_one_ilim) |-> buck_one_ilim == B1_ILIM_S0 ||
		(buck_one_ilim == B1_ILIM_S1 && $past(buck_one_ilim) == B1_ILIM_S0) ||
		(buck_one_ilim == B1_ILIM_S2 && $past(buck_one_ilim) == B1_ILIM_S1) ||
		(buck_one_ilim == B1_ILIM_RUN && $past(buck_one_ilim) == B1_ILIM_S2))
		else $error("limit step out of order");
	chk_force_hold: assert property (
		force_pwm[0] && $past(force_pwm[0], 2) |-> !buck_pfm_sleep[0])
		else $error("forced buck sleeping");
	chk_dropout_hs: assert property (
		buck_pwm_mode[0] && $past(buck_pwm_mode[0]) && $past(dropout[0]) &&
		$past(buck_one_ilim) == B1_ILIM_RUN |-> buck_hs_on[0] && !buck_ls_on[0])
		else $error("dropout not full on");
	chk_hs_ls_excl: assert property (
		(buck_hs_on & buck_ls_on) == 2'h0) else $error("both switches on");
	chk_pfm_wake: assert property (
		buck_pfm_sleep[0] && fb_below_low[0] && !fb_below_low2[0] &&
		!force_pwm[0] |=> buck_hs_on[0] || !rail_on[0])
		else $error("no pulse on low threshold");
	chk_low2_exit: assert property (
		buck_pfm_sleep[0] && fb_below_low2[0] |=>
		buck_pwm_mode[0] || !rail_on[0]) else $error("no PWM on low2");
endmodule
bind rsq_top rsq_top_props #(.DEGLITCH_CYC(DEGLITCH_CYC)) rsq_top_props_inst (
	.sys_clk(sys_clk), .rst_b(rst_b), .vin_ok(vin_ok), .dropout(dropout),
	.sequence_trigger_input(sequence_trigger_input), .reg_en(reg_en),
	.fb_below_low(fb_below_low), .fb_below_low2(fb_below_low2),
	.rail_on(rail_on), .force_pwm(force_pwm), .seq_busy(seq_busy),
	.trigger_level(trigger_level), .load_vout_default(load_vout_default),
	.buck_hs_on(buck_hs_on), .buck_ls_on(buck_ls_on),
	.buck_pwm_mode(buck_pwm_mode), .buck_pfm_sleep(buck_pfm_sleep),
	.buck_one_ilim(buck_one_ilim));

// *** testbench/rsq_host_model.sv ***
`timescale 1ns/1ps
module rsq_host_model #(
	parameter int PWR_WAIT = 160,
	parameter int HOLD = 240
)(
	input wire logic sys_clk, // Clock
	input wire logic rst_b, // Reset
	input wire logic trig_req, // Wanted trigger level
	input wire logic glitch_req, // Pulse: short noise burst
	input wire logic [3:0] pin_req, // Wanted pin enables
	output logic sequence_trigger_input, // Trigger pin
	output logic buck_one_pin_enable, // Pin
	output logic buck_two_pin_enable, // Pin
	output logic linreg_one_pin_enable, // Pin
	output logic linreg_two_pin_enable // Pin
);
	logic trig_q;
	logic [3:0] pin_q;
	logic [2:0] noise;
	int up_cnt;
	int hold_cnt;
	// Trigger requests are deferred until PWR_WAIT and HOLD have passed, and one withdrawn before then is dropped, so the bench may ask early
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_q <= 1'b0;
			pin_q <= 4'h0;
			noise <= 3'h0;
			up_cnt <= 0;
			hold_cnt <= 0;
		end else begin
			pin_q <= pin_req;
			noise <= glitch_req ? 3'h5 : noise - 3'(noise != 3'h0);
			up_cnt <= up_cnt < PWR_WAIT ? up_cnt + 1 : up_cnt;
			hold_cnt <= hold_cnt < HOLD ? hold_cnt + 1 : hold_cnt;
			if (trig_req != trig_q && up_cnt >= PWR_WAIT &&
				hold_cnt >= HOLD) begin
				trig_q <= trig_req;
				hold_cnt <= 0;
			end
		end
	end
	assign sequence_trigger_input = trig_q ^ (noise != 3'h0);
	assign {linreg_two_pin_enable, linreg_one_pin_enable} = pin_q[3:2];
	assign {buck_two_pin_enable, buck_one_pin_enable} = pin_q[1:0];
endmodule

// *** testbench/tb_rsq_top.sv ***
`timescale 1ns/1ps
module tb_rsq_top
	import rsq_pkg::*;
;
	localparam int DL[4] = '{10, 20, 30, 60};
	localparam logic [ILIM_W-1:0] L1[4] = '{B1_ILIM_S0, B1_ILIM_S1,
		B1_ILIM_S2, B1_ILIM_RUN};
	localparam logic [ILIM_W-1:0] L2[4] = '{B2_ILIM_S0, B2_ILIM_S1,
		B2_ILIM_S2, B2_ILIM_RUN};
	// Pulse walk: {low, peak, zero, high} in, {hs, ls, sleep} out
	localparam logic [6:0] PW[5] = '{7'h44, 7'h22, 7'h14, 7'h0a, 7'h19};
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic trig_req, glitch_req, vin_ok, reg_en_wr, force_pwm_wr, sw_tick;
	logic [3:0] pin_req, reg_en_wdata, rail_on, reg_en;
	logic [1:0] force_pwm_wdata, fb_below_low, fb_above_high, fb_below_low2;
	logic [1:0] pfm_peak_hit, zero_current, light_load, pwm_hs_req, dropout;
	logic [1:0] force_pwm, buck_hs_on, buck_ls_on, buck_pwm_mode, buck_pfm_sleep;
	logic sequence_trigger_input, trigger_level, seq_busy, load_vout_default;
	logic buck_one_pin_enable, buck_two_pin_enable;
	logic linreg_one_pin_enable, linreg_two_pin_enable;
	logic [ILIM_W-1:0] buck_one_ilim, buck_two_ilim;
	logic [ILIM_W-1:0] q1[$];
	logic [ILIM_W-1:0] q2[$];
	int err_count = 0;
	int tests_run = 0;
	rsq_host_model rsq_host_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
		.trig_req(trig_req), .glitch_req(glitch_req), .pin_req(pin_req),
		.sequence_trigger_input(sequence_trigger_input),
		.buck_one_pin_enable(buck_one_pin_enable),
		.buck_two_pin_enable(buck_two_pin_enable),
		.linreg_one_pin_enable(linreg_one_pin_enable),
		.linreg_two_pin_enable(linreg_two_pin_enable));
	rsq_top #(.DEGLITCH_CYC(20), .B1_ON_CYC(DL[0]), .B2_ON_CYC(DL[1]),
		.L1_ON_CYC(DL[2]), .L2_ON_CYC(DL[3]), .B1_OFF_CYC(DL[0]), .B2_OFF_CYC(DL[1]),
		.L1_OFF_CYC(DL[2]), .L2_OFF_CYC(DL[3]), .SS_STEP_CYC(4), .PFM_TICKS(32)
	) rsq_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .vin_ok(vin_ok),
		.sequence_trigger_input(sequence_trigger_input),
		.buck_one_pin_enable(buck_one_pin_enable),
		.buck_two_pin_enable(buck_two_pin_enable),
		.linreg_one_pin_enable(linreg_one_pin_enable),
		.linreg_two_pin_enable(linreg_two_pin_enable), .reg_en_wr(reg_en_wr),
		.reg_en_wdata(reg_en_wdata), .force_pwm_wr(force_pwm_wr),
		.force_pwm_wdata(force_pwm_wdata), .sw_tick(sw_tick),
		.fb_below_low(fb_below_low),
		.fb_above_high(fb_above_high), .fb_below_low2(fb_below_low2),
		.pfm_peak_hit(pfm_peak_hit), .zero_current(zero_current),
		.light_load(light_load),
		.pwm_hs_req(pwm_hs_req), .dropout(dropout), .rail_on(rail_on), .reg_en(reg_en),
		.force_pwm(force_pwm), .trigger_level(trigger_level), .seq_busy(seq_busy),
		.load_vout_default(load_vout_default), .buck_hs_on(buck_hs_on),
		.buck_ls_on(buck_ls_on), .buck_pwm_mode(buck_pwm_mode),
		.buck_pfm_sleep(buck_pfm_sleep), .buck_one_ilim(buck_one_ilim),
		.buck_two_ilim(buck_two_ilim));
	initial forever #4 sys_clk = ~sys_clk;
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge sys_clk) sw_tick <= 1'b1;
			@(posedge sys_clk) sw_tick <= 1'b0;
		end
	endtask
	task automatic wr(input logic f, input logic [3:0] v);
		@(posedge sys_clk) begin
			reg_en_wr <= !f;
			force_pwm_wr <= f;
			reg_en_wdata <= v;
			force_pwm_wdata <= v[1:0];
		end
		@(posedge sys_clk) begin
			reg_en_wr <= 1'b0;
			force_pwm_wr <= 1'b0;
		end
	endtask
	// Times each rail from the filtered edge; on selects rise or fall
	task automatic seq_walk(input logic on);
		int t[4];
		int n;
		int loads;
		t = '{-1, -1, -1, -1};
		n = 0;
		loads = 0;
		while (trigger_level !== on && n < 1000) begin
			cyc(1);
			n++;
		end
		check(32'(trigger_level), 32'(on));
		for (n = 1; n <= 80; n++) begin
			cyc(1);
			loads += 32'(load_vout_default === 1'b1);
			for (int i = 0; i < 4; i++)
				if (t[i] < 0 && rail_on[i] === on)
					t[i] = n;
		end
		for (int i = 0; i < 4; i++)
			check(32'(t[i] >= DL[i] + 1 && t[i] <= DL[i] + 4), 32'h1);
		check(loads, 32'(on));
		check(32'(seq_busy), 32'h0);
	endtask
	initial begin
		{trig_req, glitch_req, reg_en_wr, force_pwm_wr, sw_tick} = 5'h0;
		{pin_req, reg_en_wdata, force_pwm_wdata} = 10'h0;
		{fb_below_low, fb_above_high, fb_below_low2, pfm_peak_hit} = 8'h0;
		{zero_current, light_load, pwm_hs_req, dropout} = 8'h0;
		vin_ok = 1'b1;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		cyc(1);
		check(reg_en, REG_EN_RST);
		check(rail_on, 4'h0);
		check(buck_one_ilim, B1_ILIM_S0);
		check(buck_two_ilim, B2_ILIM_S0);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk) pin_req <= 4'h1 << i;
			cyc(4);
			check(rail_on, 4'h1 << i);
		end
		@(posedge sys_clk) pin_req <= 4'hf;
		wr(1'b0, 4'hd);
		cyc(3);
		check(reg_en, 4'hd);
		check(rail_on, 4'hd);
		@(posedge sys_clk) vin_ok <= 1'b0;
		cyc(3);
		check(rail_on, 4'h0);
		@(posedge sys_clk) vin_ok <= 1'b1;
		wr(1'b0, 4'hf);
		@(posedge sys_clk) pin_req <= 4'h0;
		cyc(4);
		@(posedge sys_clk) pin_req <= 4'h3;
		#1;
		q1.push_back(buck_one_ilim);
		q2.push_back(buck_two_ilim);
		for (int n = 0; n < 40; n++) begin
			cyc(1);
			if (buck_one_ilim !== q1[$])
				q1.push_back(buck_one_ilim);
			if (buck_two_ilim !== q2[$])
				q2.push_back(buck_two_ilim);
		end
		for (int i = 1; i <= 4; i++) begin
			check(q1[q1.size() - i], L1[4 - i]);
			check(q2[q2.size() - i], L2[4 - i]);
		end
		check({buck_hs_on[0], buck_ls_on[0]}, 2'h1);
		@(posedge sys_clk) light_load <= 2'h1;
		ticks(31);
		cyc(2);
		check(buck_pfm_sleep, 2'h0);
		ticks(1);
		cyc(2);
		check(buck_pfm_sleep, 2'h1);
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk) {fb_below_low[0], pfm_peak_hit[0],
				zero_current[0], fb_above_high[0]} <= PW[i][6:3];
			cyc(2);
			check({buck_hs_on[0], buck_ls_on[0], buck_pfm_sleep[0]},
				PW[i][2:0]);
		end
		@(posedge sys_clk) {zero_current[0], fb_above_high[0],
			fb_below_low2[0]} <= 3'h1;
		cyc(2);
		check({buck_pwm_mode[0], buck_pfm_sleep[0]}, 2'h2);
		@(posedge sys_clk) fb_below_low2 <= 2'h0;
		ticks(32);
		cyc(2);
		check(buck_pfm_sleep, 2'h1);
		wr(1'b1, 4'h1);
		cyc(3);
		check(force_pwm, 2'h1);
		check({buck_pwm_mode[0], buck_pfm_sleep[0]}, 2'h2);
		ticks(34);
		cyc(2);
		check(buck_pfm_sleep, 2'h0);
		@(posedge sys_clk) pwm_hs_req <= 2'h1;
		cyc(3);
		check({buck_hs_on[0], buck_ls_on[0]}, 2'h2);
		@(posedge sys_clk) pwm_hs_req <= 2'h0;
		cyc(3);
		check({buck_hs_on[0], buck_ls_on[0]}, 2'h1);
		@(posedge sys_clk) dropout <= 2'h1;
		cyc(6);
		check({buck_hs_on[0], buck_ls_on[0]}, 2'h2);
		@(posedge sys_clk) pin_req <= 4'h0;
		cyc(4);
		@(posedge sys_clk) glitch_req <= 1'b1;
		@(posedge sys_clk) glitch_req <= 1'b0;
		cyc(30);
		check(32'(trigger_level), 32'h0);
		@(posedge sys_clk) trig_req <= 1'b1;
		seq_walk(1'b1);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk) pin_req <= 4'h1 << i;
			cyc(3);
			@(posedge sys_clk) pin_req <= 4'h0;
			cyc(3);
			check(rail_on, 4'hf);
		end
		wr(1'b0, 4'h7);
		cyc(3);
		check(rail_on, 4'h7);
		wr(1'b0, 4'hf);
		@(posedge sys_clk) trig_req <= 1'b0;
		seq_walk(1'b0);
		wr(1'b0, 4'h0);
		@(posedge sys_clk) rst_b <= 1'b0;
		cyc(2);
		check(force_pwm, 2'h0);
		@(posedge sys_clk) rst_b <= 1'b1;
		cyc(2);
		check(force_pwm, FORCE_PWM_RST);
		check(reg_en, REG_EN_RST);
		check(rail_on, 4'h0);
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		tally_and_finish();
	end
endmodule
